/* File: hw/ref_ladder_regs.vh */
// Constants for the reference ladder control block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef REF_LADDER_REGS_VH
`define REF_LADDER_REGS_VH
// Register indices as printed; byte address is four times the index.
`define COMPARATOR_CONFIG_INDEX 8'h9C
`define REFERENCE_LADDER_CONTROL_INDEX 8'h9D
`define COMPARATOR_CONFIG_ADDR 10'h270
`define REFERENCE_LADDER_CONTROL_ADDR 10'h274
// Field positions of the ladder control register.
`define LADDER_POWER_ON_BIT 7
`define LADDER_PIN_OUTPUT_ENABLE_BIT 6
`define LADDER_RANGE_SELECT_BIT 5
`define LADDER_UNUSED_BIT 4
`define LADDER_TAP_MSB 3
`define LADDER_TAP_LSB 0
`define LADDER_WRITE_MASK 8'hEF
// Comparator configuration fields.
`define COMPARATOR_MODE_MSB 2
`define COMPARATOR_MODE_LSB 0
`define COMPARATOR_WRITE_MASK 8'h3F
`define COMPARATOR_MODE_LADDER 3'h6
`define COMPARATOR_MODE_OFF 3'h7
// Reset values.
`define REFERENCE_LADDER_CONTROL_RESET 8'h00
`define COMPARATOR_CONFIG_RESET 8'h07
`endif

/* File: hw/byte_reg.v */
// One 8-bit software register with a per-bit write mask.
// Assumes a single clock and an asynchronous active-low reset.
module byte_reg #(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hFF
) (
    input wire pclk,
    input wire presetn,
    input wire write_strobe,
    input wire [7:0] write_data,
    output reg [7:0] value
);

    // Masked bits keep their reset value, so unimplemented bits always read as the matching RESET_VALUE bits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= RESET_VALUE;
        end else if (write_strobe) begin
            value <= (write_data & WRITE_MASK) | (value & ~WRITE_MASK);
        end
    end

endmodule // byte_reg

/* File: hw/ref_ladder_control.v */
// Reference ladder control: ladder control register and comparator configuration register on APB.
// Assumes one 40 MHz clock pclk, asynchronous active-low presetn and an APB master with 32-bit data.
// The master keeps address, direction and write data steady from the setup cycle until pready.
// Each register sits alone in an aligned word; only byte lane 0 carries data, upper lanes read zero.
// Timing: pready answers in the first access cycle; controls follow one clock after the write edge.
// Limitation: there are no byte strobes, so every write replaces the whole writable low byte.
// Reset: presetn loads both registers and all outputs with their reset values at once, without waiting for a clock.
// The analog ladder, its pin switch and the comparators sit outside and see only the registered controls.
`include "ref_ladder_regs.vh"

module ref_ladder_control (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg ladder_power_on,
    output reg ladder_pin_output_enable,
    output reg ladder_range_select,
    output reg [3:0] ladder_tap_select,
    output reg [2:0] comparator_mode_field,
    output reg ladder_to_comparators,
    output reg comparators_off
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    wire [7:0] ladder_ctrl;
    wire [7:0] comp_cfg;
    wire hit_ladder;
    wire hit_comp;
    wire setup_phase;
    wire access_phase;

    // All 32 address bits decode; upper address bits must be zero to hit.
    assign hit_ladder = (paddr == {22'h000000, `REFERENCE_LADDER_CONTROL_ADDR});
    assign hit_comp = (paddr == {22'h000000, `COMPARATOR_CONFIG_ADDR});
    assign setup_phase = psel && !penable;
    // The write lands in the access cycle where pready is already high.
    assign access_phase = psel && penable && pready;

    // Write strobes, one per register, each high only in the completing access cycle.
    wire write_ladder;
    wire write_comp;
    assign write_ladder = access_phase && pwrite && hit_ladder;
    assign write_comp = access_phase && pwrite && hit_comp;

    // Named views of the stored fields, so the output logic reads like the register map.
    wire ctrl_power;
    wire ctrl_pin;
    wire ctrl_range;
    wire [3:0] ctrl_tap;
    wire [2:0] cfg_mode;
    assign ctrl_power = ladder_ctrl[`LADDER_POWER_ON_BIT];
    assign ctrl_pin = ladder_ctrl[`LADDER_PIN_OUTPUT_ENABLE_BIT];
    assign ctrl_range = ladder_ctrl[`LADDER_RANGE_SELECT_BIT];
    assign ctrl_tap = ladder_ctrl[`LADDER_TAP_MSB:`LADDER_TAP_LSB];
    assign cfg_mode = comp_cfg[`COMPARATOR_MODE_MSB:`COMPARATOR_MODE_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    // Ladder control, bit 4 masked off so writes cannot reach it.
    byte_reg #(
        .RESET_VALUE(`REFERENCE_LADDER_CONTROL_RESET),
        .WRITE_MASK(`LADDER_WRITE_MASK)
    ) ladder_reg (
        .pclk(pclk),
        .presetn(presetn),
        .write_strobe(write_ladder),
        .write_data(pwdata[7:0]),
        .value(ladder_ctrl)
    );

    // Comparator configuration; the comparator output bits 7:6 are not modelled and read zero.
    byte_reg #(
        .RESET_VALUE(`COMPARATOR_CONFIG_RESET),
        .WRITE_MASK(`COMPARATOR_WRITE_MASK)
    ) comp_reg (
        .pclk(pclk),
        .presetn(presetn),
        .write_strobe(write_comp),
        .write_data(pwdata[7:0]),
        .value(comp_cfg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer: no wait state, so pready rises in the first access cycle.
    //
    // The answer is split into a read multiplexer, a next-state block and the flops, so that
    // every bus output leaves a flop and the mux stays free of the protocol timing.

    reg [7:0] read_byte;
    reg next_pready;
    reg next_pslverr;
    reg [31:0] next_prdata;

    // Read multiplexer; both hits can never be high together, so the default covers misses.
    always @* begin
        read_byte = 8'h00;
        case ({hit_ladder, hit_comp})
            2'b10: begin
                read_byte = ladder_ctrl;
            end
            2'b01: begin
                read_byte = comp_cfg;
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    // Only a setup cycle raises the answer; in every other cycle pready and pslverr fall,
    // which makes them one-cycle pulses, while prdata holds until the next setup.
    always @* begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (setup_phase) begin
            next_pready = 1'b1;
            // Unmapped addresses answer with an error and zero data.
            next_pslverr = !(hit_ladder || hit_comp);
            // A write clears the read data, so an old byte never poses as an answer.
            if (pwrite) begin
                next_prdata = 32'h00000000;
            end else begin
                next_prdata = {24'h000000, read_byte};
            end
        end
    end

    // Answer flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ladder and comparator controls, registered so every output comes from a flop.

    reg next_ladder_power_on;
    reg next_ladder_pin_output_enable;
    reg next_ladder_range_select;
    reg [3:0] next_ladder_tap_select;
    reg [2:0] next_comparator_mode_field;
    reg next_ladder_to_comparators;
    reg next_comparators_off;

    // Gating by the power bit keeps the pin switch and tap decoder idle when the
    // ladder is off, so no path draws current through a dead ladder.
    // The stored bits survive power-down, so software finds them again at power-up;
    // the range bit passes ungated, as it only picks a tap set and switches no current.
    always @* begin
        next_ladder_power_on = ctrl_power;
        next_ladder_range_select = ctrl_range;
        if (ctrl_power) begin
            next_ladder_pin_output_enable = ctrl_pin;
            next_ladder_tap_select = ctrl_tap;
        end else begin
            next_ladder_pin_output_enable = 1'b0;
            next_ladder_tap_select = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator mode decode.

    // The ladder reaches the comparators in one mode only; the off mode is also the reset mode.
    // Both decodes are registered with the mode itself, so they never disagree with it.
    always @* begin
        next_comparator_mode_field = cfg_mode;
        next_ladder_to_comparators = (cfg_mode == `COMPARATOR_MODE_LADDER);
        next_comparators_off = (cfg_mode == `COMPARATOR_MODE_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output flops.

    // The reset values match what the next-state logic gives for the reset register contents,
    // so the first clock after reset changes no output.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_power_on <= 1'b0;
            ladder_pin_output_enable <= 1'b0;
            ladder_range_select <= 1'b0;
            ladder_tap_select <= 4'h0;
            comparator_mode_field <= `COMPARATOR_MODE_OFF;
            ladder_to_comparators <= 1'b0;
            comparators_off <= 1'b1;
        end else begin
            ladder_power_on <= next_ladder_power_on;
            ladder_pin_output_enable <= next_ladder_pin_output_enable;
            ladder_range_select <= next_ladder_range_select;
            ladder_tap_select <= next_ladder_tap_select;
            comparator_mode_field <= next_comparator_mode_field;
            ladder_to_comparators <= next_ladder_to_comparators;
            comparators_off <= next_comparators_off;
        end
    end

endmodule // ref_ladder_control

/* File: dv/ref_ladder_chk.sv */
// Checker for ref_ladder_control: bus timing, field routing, gating, reset.
// Sees only the top module's ports; bound at the foot.
`include "ref_ladder_regs.vh"
module ref_ladder_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire ladder_power_on,
    input wire ladder_pin_output_enable,
    input wire ladder_range_select,
    input wire [3:0] ladder_tap_select,
    input wire [2:0] comparator_mode_field,
    input wire ladder_to_comparators,
    input wire comparators_off
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded writes keep the properties short.
    wire hl = paddr == `REFERENCE_LADDER_CONTROL_ADDR;
    wire hc = paddr == `COMPARATOR_CONFIG_ADDR;
    wire wl = psel && penable && pready && pwrite && hl;
    wire wc = psel && penable && pready && pwrite && hc;
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("late");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("long");
    a_decode_error: assert property (pready |-> pslverr == !(hl || hc)) else $error("decode");
    a_unused_reads_zero: assert property (pready && hl |-> !prdata[4]) else $error("bit4");
    a_ladder_follows: assert property (wl |-> ##2 ladder_power_on == $past(pwdata[7], 2)
        && ladder_range_select == $past(pwdata[5], 2)
        && ladder_tap_select == ($past(pwdata[3:0], 2) & {4{$past(pwdata[7], 2)}})) else $error("ladder");
    a_pin_needs_power: assert property (ladder_pin_output_enable |-> ladder_power_on) else $error("pin");
    a_tap_needs_power: assert property (!ladder_power_on |-> ladder_tap_select == 4'h0) else $error("tap");
    a_mode_to_ladder: assert property (wc |-> ##2 comparator_mode_field == $past(pwdata[2:0], 2)
        && ladder_to_comparators == ($past(pwdata[2:0], 2) == 3'h6)) else $error("mode");
    a_mode_off: assert property (wc |-> ##2 comparators_off == ($past(pwdata[2:0], 2) == 3'h7)) else $error("off");
    a_reset_state: assert property ($rose(presetn) |-> comparators_off && !ladder_power_on
        && !ladder_to_comparators && comparator_mode_field == 3'h7) else $error("reset");
    c_ladder_write: cover property (wl);
    c_ladder_mode: cover property (wc ##2 ladder_to_comparators);
    c_bad_address: cover property (pready && pslverr);
    c_pin_gated: cover property (wl && pwdata[6] && !pwdata[7]);
endmodule // ref_ladder_chk
bind ref_ladder_control ref_ladder_chk u_chk (.*);

/* File: dv/ref_ladder_control_bench.sv */
// Self-checking bench for ref_ladder_control: APB master, read notes queue, output checks.
// Assumes the checker is bound to the design.
module ref_ladder_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0;
    wire [31:0] prdata;
    wire pready, pslverr, pw, po, rs, lc, co;
    wire [3:0] tap;
    wire [2:0] mode;
    int fails = 0, n_tests = 0;
    logic [33:0] q[$];
    logic [33:0] nt;
    logic [7:0] d;
    localparam logic [31:0] L = 32'h274, C = 32'h270;
    ref_ladder_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ladder_power_on(pw), .ladder_pin_output_enable(po), .ladder_range_select(rs),
        .ladder_tap_select(tap), .comparator_mode_field(mode), .ladder_to_comparators(lc),
        .comparators_off(co));
    always #12.5 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (e !== s) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One transfer; the note {write, error, data} is queued for the monitor.
    task apb(input logic [31:0] a, input logic [7:0] w, input logic wr, input logic [32:0] e);
        int n;
        q.push_back({wr, e});
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, 24'h0, w};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            fails++;
            tally_and_finish;
        end
    endtask
    // The monitor compares each answer with the oldest note.
    always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
        nt = q.pop_front();
        chk("pslverr", nt[32], pslverr);
        if (!nt[33]) chk("prdata", nt[31:0], prdata);
    end
    initial begin
        void'($urandom(47302));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 2; k++) begin
            apb(L, 0, 0, 0);
            apb(C, 0, 0, 7);
            #1;
            chk("reset_power", 0, pw);
            chk("reset_tap", 0, tap);
            chk("reset_off", 1, co);
            chk("reset_mode", 7, mode);
            for (int i = 0; i < 8 && k == 0; i++) begin
                d = 8'($urandom);
                apb(L, d, 1, 0);
                apb(L, 0, 0, d & 8'hEF);
                #1;
                chk("power", d[7], pw);
                chk("pin", d[7] & d[6], po);
                chk("range", d[5], rs);
                chk("tap", d[7] ? d[3:0] : 4'h0, tap);
                d = {5'($urandom), i[2:0]};
                apb(C, d, 1, 0);
                apb(C, 0, 0, d & 8'h3F);
                #1;
                chk("mode", i[2:0], mode);
                chk("ladder_sel", i == 6, lc);
                chk("off", i == 7, co);
            end
            apb(32'h278, 8'hFF, 1, 33'h100000000);
            apb(32'h278, 0, 0, 33'h100000000);
            presetn <= 0;
            repeat (2) @(posedge pclk);
            presetn <= 1;
        end
        tally_and_finish;
    end
endmodule // ref_ladder_control_bench
